/* File: rtl/tcs_defs.svh */
// Register indices, field positions and count constants of the clock, serial and interrupt block
`ifndef TCS_DEFS_SVH
`define TCS_DEFS_SVH
`define TCS_IDX_TENTHS 4'h8
`define TCS_IDX_SECONDS 4'h9
`define TCS_IDX_MINUTES 4'hA
`define TCS_IDX_HOURS 4'hB
`define TCS_IDX_SERIAL 4'hC
`define TCS_IDX_IRQ 4'hD
`define TCS_IDX_CTRL_A 4'hE
`define TCS_IDX_CTRL_B 4'hF
`define TCS_BIT_RATE_SEL 7
`define TCS_BIT_DIR_SEL 6
`define TCS_BIT_ALARM_SEL 7
`define TCS_BIT_SET_CLEAR 7
`define TCS_BIT_SUMMARY 7
`define TCS_SRC_TIMER_A 0
`define TCS_SRC_TIMER_B 1
`define TCS_SRC_ALARM 2
`define TCS_SRC_SERIAL 3
`define TCS_SRC_EDGE 4
`define TCS_PRE_60HZ 3'h5
`define TCS_PRE_50HZ 3'h4
`define TCS_BITS_LAST 3'h7
`define TCS_HR_ELEVEN 5'h11
`define TCS_HR_TWELVE 5'h12
`define TCS_HR_ONE 5'h01
`define TCS_DIGIT_NINE 4'h9
`define TCS_TENS_FIVE 3'h5
`endif

/* File: rtl/tcs_pkg.sv */
// Types shared by the clock, serial and interrupt block
package tcs_pkg;
  // Transmit shifter state
  typedef enum logic [0:0] {
    TCS_TX_IDLE = 1'b0,
    TCS_TX_SHIFT = 1'b1
  } tcs_tx_state_t;
endpackage

/* File: rtl/tcs_top.sv */
// Time-of-day clock with alarm, 8-bit serial shift port and five-source interrupt unit behind APB
// Function
// - 12-hour AM/PM clock, tenths, four registers
// - BCD read layout, unused bits zero
// - Advanced by mains pin, 60/50 Hz
// - Alarm shares addresses, write-only via select
// - Time equal alarm sets alarm flag
// - Hours write stops the clock
// - Tenths write restarts the clock
// - Hours read freezes copy until tenths read
// - 8-bit shifter, buffer, direction bit
// - Receive samples on clock rise, 8 bits
// - Transmit clock toggles per timer A underflow
// - Buffer write starts send if continuous
// - Drive clock, MSB first, change on fall
// - After 8 bits interrupt, reload seamlessly
// - Idle: clock high, data holds last bit
// - Clock and data pins are open drain
// - Five status bits, bits 6:5 zero
// - Events set status; masked ones request
// - Status read clears and releases request
// - Mask write sets or clears by bit 7
// - Rate select bit 7: 1=50, 0=60
// - Direction bit 6: 1=transmit, 0=receive
// - Edge input falling sets edge flag
//
// The APB register port is this design's own decision.
`timescale 1ns/1ps
`include "tcs_defs.svh"
module tcs_top
  import tcs_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [5:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Timer A and B status from the timer logic on pclk
  input wire logic timer_a_underflow,
  input wire logic timer_a_continuous_run,
  input wire logic timer_b_underflow,
  // Asynchronous pins
  input wire logic mains_rate_pin,
  input wire logic edge_flag_pin,
  // Open-drain count clock pin
  input wire logic count_clock_pin_i,
  output logic count_clock_pin_o,
  output logic count_clock_pin_oe_n,
  // Open-drain serial data pin
  input wire logic serial_pin_i,
  output logic serial_pin_o,
  output logic serial_pin_oe_n,
  // Interrupt request, active low
  output logic interrupt_request_line_n
);

  // Pin synchronisers: stage 1 feeds stage 2 only; stage 3 is for edge detection
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic [3:0] sync3_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= 4'hF;
      sync2_q <= 4'hF;
      sync3_q <= 4'hF;
    end else begin
      sync1_q <= {serial_pin_i, count_clock_pin_i, edge_flag_pin, mains_rate_pin};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end
  // Edge strobes on synchronised pins
  logic mains_rise;
  logic edge_fall;
  logic cnt_rise;
  assign mains_rise = sync2_q[0] & ~sync3_q[0];
  assign edge_fall = ~sync2_q[1] & sync3_q[1];
  assign cnt_rise = sync2_q[2] & ~sync3_q[2];

  // APB decode; one wait state so read data comes from a flop
  logic [3:0] idx;
  logic aligned;
  logic mapped;
  logic access;
  logic done;
  assign idx = paddr[5:2];
  assign aligned = (paddr[1:0] == 2'h0);
  assign mapped = aligned && (idx >= `TCS_IDX_TENTHS);
  assign access = psel & penable;
  assign done = access & pready;
  // Completion strobes for writes and reads of mapped registers
  logic wr_ok;
  logic rd_ok;
  assign wr_ok = done & pwrite & mapped;
  assign rd_ok = done & ~pwrite & mapped;

  // Control registers
  logic [7:0] ctrl_a_q;
  logic [7:0] ctrl_b_q;
  logic [4:0] mask_q;
  logic [4:0] status_q;
  logic ir_q;
  // BCD time: tenths, seconds, minutes, hours {pm, tens, units}
  logic [3:0] tenths_q;
  logic [6:0] sec_q;
  logic [6:0] min_q;
  logic [5:0] hr_q;
  logic pm_q;
  // Alarm copy and read latch
  logic [3:0] al_tenths_q;
  logic [6:0] al_sec_q;
  logic [6:0] al_min_q;
  logic [5:0] al_hr_q;
  logic al_pm_q;
  logic [31:0] snap_q;
  logic latch_q;
  logic run_q;
  logic [2:0] pre_q;
  logic tick_q;
  // Serial state
  logic [7:0] buf_q;
  logic [7:0] shift_q;
  logic [2:0] bits_q;
  logic pend_q;
  tcs_tx_state_t tx_q;

  // Live time as one word, reads in BCD with unused bits zero
  logic [31:0] live_time;
  assign live_time = {pm_q, 2'h0, hr_q[4:0], 1'b0, min_q, 1'b0, sec_q, 4'h0, tenths_q};

  // Read mux
  logic [7:0] rd_byte;
  logic [31:0] rd_time;
  always_comb begin
    rd_time = latch_q ? snap_q : live_time;
    case (idx)
      `TCS_IDX_TENTHS: rd_byte = rd_time[7:0];
      `TCS_IDX_SECONDS: rd_byte = rd_time[15:8];
      `TCS_IDX_MINUTES: rd_byte = rd_time[23:16];
      `TCS_IDX_HOURS: rd_byte = rd_time[31:24];
      `TCS_IDX_SERIAL: rd_byte = buf_q;
      `TCS_IDX_IRQ: rd_byte = {ir_q, 2'h0, status_q};
      `TCS_IDX_CTRL_A: rd_byte = ctrl_a_q;
      `TCS_IDX_CTRL_B: rd_byte = ctrl_b_q;
      default: rd_byte = 8'h00;
    endcase
  end

  // APB answer; unmapped or misaligned gets pslverr
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready <= access & ~pready;
      if (access && !pready) begin
        prdata <= (pwrite || !mapped) ? 32'h0 : {24'h0, rd_byte};
        pslverr <= ~mapped;
      end
    end
  end

  // Control registers for rate, direction and alarm select
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_a_q <= 8'h00;
      ctrl_b_q <= 8'h00;
    end else if (wr_ok && idx == `TCS_IDX_CTRL_A) begin
      // Only select bits are stored here; timer bits live in the timer logic
      ctrl_a_q <= {pwdata[`TCS_BIT_RATE_SEL], pwdata[`TCS_BIT_DIR_SEL], 6'h00};
    end else if (wr_ok && idx == `TCS_IDX_CTRL_B) begin
      ctrl_b_q <= {pwdata[`TCS_BIT_ALARM_SEL], 7'h00};
    end
  end

  // Time write strobes, steered by the alarm select
  logic alarm_sel;
  logic tod_wr;
  logic al_wr;
  assign alarm_sel = ctrl_b_q[`TCS_BIT_ALARM_SEL];
  // writes go to alarm when select is set
  assign tod_wr = wr_ok & ~alarm_sel;
  assign al_wr = wr_ok & alarm_sel;

  // Mains prescaler: six pulses per tenth at 60 Hz, five at 50 Hz
  logic [2:0] pre_last;
  assign pre_last = ctrl_a_q[`TCS_BIT_RATE_SEL] ? `TCS_PRE_50HZ : `TCS_PRE_60HZ;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_q <= 3'h0;
      tick_q <= 1'b0;
    end else begin
      tick_q <= 1'b0;
      if (!run_q) begin
        // Prescaler restarts so the first tenth is full length
        pre_q <= 3'h0;
      end else if (mains_rise) begin
        if (pre_q >= pre_last) begin
          pre_q <= 3'h0;
          tick_q <= 1'b1;
        end else begin
          pre_q <= pre_q + 3'h1;
        end
      end
    end
  end

  // Run control: stopped out of reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_q <= 1'b0;
    end else if (tod_wr && idx == `TCS_IDX_HOURS) begin
      run_q <= 1'b0;
    end else if (tod_wr && idx == `TCS_IDX_TENTHS) begin
      run_q <= 1'b1;
    end
  end

  // BCD counting with carry; writes load fields directly
  // tenths, seconds, minutes, hours
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tenths_q <= 4'h0;
      sec_q <= 7'h00;
      min_q <= 7'h00;
      hr_q <= 6'h01;
      pm_q <= 1'b0;
    end else if (tod_wr) begin
      case (idx)
        `TCS_IDX_TENTHS: tenths_q <= pwdata[3:0];
        `TCS_IDX_SECONDS: sec_q <= pwdata[6:0];
        `TCS_IDX_MINUTES: min_q <= pwdata[6:0];
        `TCS_IDX_HOURS: begin
          hr_q <= {1'b0, pwdata[4:0]};
          pm_q <= pwdata[7];
        end
        default: begin
        end
      endcase
    end else if (tick_q) begin
      if (tenths_q != `TCS_DIGIT_NINE) begin
        tenths_q <= tenths_q + 4'h1;
      end else begin
        tenths_q <= 4'h0;
        if (sec_q[3:0] != `TCS_DIGIT_NINE) begin
          sec_q <= sec_q + 7'h01;
        end else if (sec_q[6:4] != `TCS_TENS_FIVE) begin
          sec_q <= {sec_q[6:4] + 3'h1, 4'h0};
        end else begin
          sec_q <= 7'h00;
          if (min_q[3:0] != `TCS_DIGIT_NINE) begin
            min_q <= min_q + 7'h01;
          end else if (min_q[6:4] != `TCS_TENS_FIVE) begin
            min_q <= {min_q[6:4] + 3'h1, 4'h0};
          end else begin
            min_q <= 7'h00;
            // 11 to 12 toggles PM, 12 wraps to 1
            if (hr_q[4:0] == `TCS_HR_ELEVEN) begin
              hr_q <= {1'b0, `TCS_HR_TWELVE};
              pm_q <= ~pm_q;
            end else if (hr_q[4:0] == `TCS_HR_TWELVE) begin
              hr_q <= {1'b0, `TCS_HR_ONE};
            end else if (hr_q[3:0] == `TCS_DIGIT_NINE) begin
              hr_q <= 6'h10;
            end else begin
              hr_q <= hr_q + 6'h01;
            end
          end
        end
      end
    end
  end

  // Alarm registers, write-only from the bus
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      al_tenths_q <= 4'h0;
      al_sec_q <= 7'h00;
      al_min_q <= 7'h00;
      al_hr_q <= 6'h00;
      al_pm_q <= 1'b0;
    end else if (al_wr) begin
      case (idx)
        `TCS_IDX_TENTHS: al_tenths_q <= pwdata[3:0];
        `TCS_IDX_SECONDS: al_sec_q <= pwdata[6:0];
        `TCS_IDX_MINUTES: al_min_q <= pwdata[6:0];
        `TCS_IDX_HOURS: begin
          al_hr_q <= {1'b0, pwdata[4:0]};
          al_pm_q <= pwdata[7];
        end
        default: begin
        end
      endcase
    end
  end

  // Alarm fires once, on the tick after which time equals alarm
  logic tick_d_q;
  logic alarm_ev;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_d_q <= 1'b0;
    end else begin
      tick_d_q <= tick_q;
    end
  end
  assign alarm_ev = tick_d_q && (live_time == {al_pm_q, 2'h0, al_hr_q[4:0], 1'b0, al_min_q,
                                              1'b0, al_sec_q, 4'h0, al_tenths_q});

  // Read latch: a carry cannot tear a multi-register read unless it lands on the edge that registers the hours byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latch_q <= 1'b0;
      snap_q <= 32'h0;
    // hours read freezes, tenths read releases
    end else if (rd_ok && idx == `TCS_IDX_HOURS && !latch_q) begin
      latch_q <= 1'b1;
      snap_q <= live_time;
    // software must read tenths after hours
    end else if (rd_ok && idx == `TCS_IDX_TENTHS) begin
      latch_q <= 1'b0;
    end
  end

  // Serial port: receive and transmit share the shifter
  logic dir_tx;
  logic serial_ev;
  logic buf_wr;
  assign dir_tx = ctrl_a_q[`TCS_BIT_DIR_SEL];
  assign buf_wr = wr_ok && idx == `TCS_IDX_SERIAL;
  // Event is one-cycle; set by the last bit in either direction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_q <= 8'h00;
      buf_q <= 8'h00;
      bits_q <= 3'h0;
      pend_q <= 1'b0;
      tx_q <= TCS_TX_IDLE;
      count_clock_pin_oe_n <= 1'b1;
      serial_pin_oe_n <= 1'b1;
      serial_ev <= 1'b0;
    end else begin
      serial_ev <= 1'b0;
      if (buf_wr) begin
        buf_q <= pwdata[7:0];
      end
      // direction bit 1 transmits, 0 receives
      if (!dir_tx) begin
        // Leaving transmit releases both pins
        tx_q <= TCS_TX_IDLE;
        pend_q <= 1'b0;
        count_clock_pin_oe_n <= 1'b1;
        serial_pin_oe_n <= 1'b1;
        // sample data on clock rise, 8 bits fill
        if (cnt_rise) begin
          shift_q <= {shift_q[6:0], sync2_q[3]};
          bits_q <= bits_q + 3'h1;
          if (bits_q == `TCS_BITS_LAST) begin
            buf_q <= {shift_q[6:0], sync2_q[3]};
            serial_ev <= 1'b1;
          end
        end
      end else begin
        if (buf_wr) begin
          pend_q <= 1'b1;
        end
        case (tx_q)
          TCS_TX_IDLE: begin
            // clock released high, data keeps last bit
            count_clock_pin_oe_n <= 1'b1;
            bits_q <= 3'h0;
            // start only with timer A running continuously
            if (pend_q && timer_a_continuous_run) begin
              shift_q <= buf_q;
              pend_q <= buf_wr;
              tx_q <= TCS_TX_SHIFT;
            end
          end
          TCS_TX_SHIFT: begin
            // one clock phase per timer A underflow
            if (timer_a_underflow) begin
              if (count_clock_pin_oe_n) begin
                // falling clock edge presents next bit, MSB first
                // open drain: low is driven, high is released
                count_clock_pin_oe_n <= 1'b0;
                serial_pin_oe_n <= shift_q[7];
                shift_q <= {shift_q[6:0], 1'b0};
              end else begin
                count_clock_pin_oe_n <= 1'b1;
                bits_q <= bits_q + 3'h1;
                // eighth rising edge ends the byte
                if (bits_q == `TCS_BITS_LAST) begin
                  serial_ev <= 1'b1;
                  if (pend_q) begin
                    shift_q <= buf_q;
                    pend_q <= buf_wr;
                  end else begin
                    tx_q <= TCS_TX_IDLE;
                  end
                end
              end
            end
          end
          default: tx_q <= TCS_TX_IDLE;
        endcase
      end
    end
  end
  // Open drain only ever pulls low
  assign count_clock_pin_o = 1'b0;
  assign serial_pin_o = 1'b0;

  // Interrupt unit
  logic [4:0] events;
  logic icr_rd;
  logic [4:0] status_kept;
  // edge input falling sets edge flag
  assign events = {edge_fall, serial_ev, alarm_ev, timer_b_underflow, timer_a_underflow};
  assign icr_rd = rd_ok && idx == `TCS_IDX_IRQ;
  // Only bits already returned are cleared; a late event survives the read
  assign status_kept = icr_rd ? (status_q & ~prdata[4:0]) : status_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q <= 5'h00;
      ir_q <= 1'b0;
      interrupt_request_line_n <= 1'b1;
    end else begin
      // every event sets status regardless of mask
      status_q <= status_kept | events;
      ir_q <= (icr_rd ? |(status_kept & mask_q) : ir_q) | |(events & mask_q);
      interrupt_request_line_n <= ~((icr_rd ? |(status_kept & mask_q) : ir_q) | |(events & mask_q));
    end
  end

  // Mask register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_q <= 5'h00;
    // bit 7 selects set or clear of written ones
    end else if (wr_ok && idx == `TCS_IDX_IRQ) begin
      if (pwdata[`TCS_BIT_SET_CLEAR]) begin
        mask_q <= mask_q | pwdata[4:0];
      end else begin
        mask_q <= mask_q & ~pwdata[4:0];
      end
    end
  end

  // Checks
  property p_ready_wait;
    @(posedge pclk) disable iff (!presetn) access && !pready |=> pready;
  endproperty
  a_ready_wait: assert property (p_ready_wait) else $error("pready not after one wait");
  property p_hours_stop;
    @(posedge pclk) disable iff (!presetn) tod_wr && idx == `TCS_IDX_HOURS |=> !run_q ##1 !tick_q;
  endproperty
  a_hours_stop: assert property (p_hours_stop) else $error("clock runs after hours write");
  property p_tenths_start;
    @(posedge pclk) disable iff (!presetn) tod_wr && idx == `TCS_IDX_TENTHS |=> run_q;
  endproperty
  a_tenths_start: assert property (p_tenths_start) else $error("clock not started");
  property p_latch_hold;
    @(posedge pclk) disable iff (!presetn) latch_q && !(rd_ok && idx == `TCS_IDX_TENTHS) |=> latch_q && $stable(snap_q);
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("read latch dropped early");
  property p_mask_set;
    @(posedge pclk) disable iff (!presetn)
      wr_ok && idx == `TCS_IDX_IRQ && pwdata[7] |=> mask_q == ($past(mask_q) | $past(pwdata[4:0]));
  endproperty
  a_mask_set: assert property (p_mask_set) else $error("mask set wrong");
  property p_masked_irq;
    @(posedge pclk) disable iff (!presetn) |(events & mask_q) |=> ir_q && !interrupt_request_line_n;
  endproperty
  a_masked_irq: assert property (p_masked_irq) else $error("masked event gave no request");
  property p_edge_flag;
    @(posedge pclk) disable iff (!presetn) edge_fall |=> status_q[`TCS_SRC_EDGE];
  endproperty
  a_edge_flag: assert property (p_edge_flag) else $error("edge flag not set");
  property p_serial_flag;
    @(posedge pclk) disable iff (!presetn) serial_ev |=> status_q[`TCS_SRC_SERIAL];
  endproperty
  a_serial_flag: assert property (p_serial_flag) else $error("serial flag not set");
  property p_idle_release;
    @(posedge pclk) disable iff (!presetn) tx_q == TCS_TX_IDLE ##1 tx_q == TCS_TX_IDLE |-> count_clock_pin_oe_n;
  endproperty
  a_idle_release: assert property (p_idle_release) else $error("clock pin held while idle");
  property p_clear_read;
    @(posedge pclk) disable iff (!presetn) icr_rd && events == 5'h00 |=> (status_q & $past(prdata[4:0])) == 5'h00;
  endproperty
  a_clear_read: assert property (p_clear_read) else $error("status not cleared by read");
  c_alarm: cover property (@(posedge pclk) disable iff (!presetn) alarm_ev);
  c_tx_byte: cover property (@(posedge pclk) disable iff (!presetn) serial_ev && dir_tx);
  c_rx_byte: cover property (@(posedge pclk) disable iff (!presetn) serial_ev && !dir_tx);

endmodule

/* File: sim/tcs_peer.sv */
// Peer serial chip sharing the open-drain clock and data lines
`timescale 1ns/1ps
module tcs_peer (
  // Clock
  input wire logic pclk,
  // Device pin enables, low while pulling low
  input wire logic cnt_oe_n,
  input wire logic ser_oe_n,
  // Resolved wires
  output logic cnt_w,
  output logic ser_w,
  // What the peer heard as a receiver
  output logic [7:0] rx_data,
  output logic [7:0] rx_count
);
  logic drv_cnt_n; // Peer pulls clock low when 0
  logic drv_ser_n; // Peer pulls data low when 0
  logic busy; // Peer is master, so it does not listen

  initial begin
    drv_cnt_n = 1'b1;
    drv_ser_n = 1'b1;
    busy = 1'b0;
    rx_data = 8'h00;
    rx_count = 8'h00;
  end

  assign cnt_w = cnt_oe_n & drv_cnt_n;
  assign ser_w = ser_oe_n & drv_ser_n;

  // Shift in on each rising clock while another chip is master
  always @(posedge cnt_w) begin
    if (!busy) begin
      rx_data <= {rx_data[6:0], ser_w};
      rx_count <= rx_count + 8'h01;
    end
  end

  // Act as master: MSB first, data changes while clock is low; half sets the speed
  task automatic send(input logic [7:0] b, input int half);
    busy = 1'b1;
    for (int i = 7; i >= 0; i--) begin
      @(posedge pclk);
      drv_cnt_n <= 1'b0;
      drv_ser_n <= b[i];
      repeat (half) @(posedge pclk);
      drv_cnt_n <= 1'b1;
      repeat (half) @(posedge pclk);
    end
    // Released line floats back to the pull-up level
    drv_ser_n <= 1'b1;
    @(posedge pclk);
    busy = 1'b0;
  endtask
endmodule

/* File: sim/tcs_top_tb.sv */
// Register-level testbench of the clock, serial and interrupt block
`timescale 1ns/1ps
`include "tcs_defs.svh"
module tcs_top_tb;
  localparam logic [5:0] A_TEN = {`TCS_IDX_TENTHS, 2'b00};
  localparam logic [5:0] A_SEC = {`TCS_IDX_SECONDS, 2'b00};
  localparam logic [5:0] A_MIN = {`TCS_IDX_MINUTES, 2'b00};
  localparam logic [5:0] A_HR = {`TCS_IDX_HOURS, 2'b00};
  localparam logic [5:0] A_SER = {`TCS_IDX_SERIAL, 2'b00};
  localparam logic [5:0] A_IRQ = {`TCS_IDX_IRQ, 2'b00};
  localparam logic [5:0] A_CA = {`TCS_IDX_CTRL_A, 2'b00};
  localparam logic [5:0] A_CB = {`TCS_IDX_CTRL_B, 2'b00};
  // Bus and pins
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [5:0] paddr;
  logic [31:0] pwdata, prdata, rd_q;
  logic ta_uf, ta_run, tb_uf, mains, edge_pin, irq_n, e_q;
  logic cnt_oe_n, ser_oe_n, cnt_w, ser_w, cnt_o, ser_o;
  logic [7:0] rx_data, rx_count, c0;
  int err_total, checks;

  tcs_top u_tcs_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer_a_underflow(ta_uf), .timer_a_continuous_run(ta_run), .timer_b_underflow(tb_uf),
    .mains_rate_pin(mains), .edge_flag_pin(edge_pin), .count_clock_pin_i(cnt_w), .count_clock_pin_o(cnt_o),
    .count_clock_pin_oe_n(cnt_oe_n), .serial_pin_i(ser_w), .serial_pin_o(ser_o), .serial_pin_oe_n(ser_oe_n),
    .interrupt_request_line_n(irq_n));

  tcs_peer u_tcs_peer (.pclk(pclk), .cnt_oe_n(cnt_oe_n), .ser_oe_n(ser_oe_n), .cnt_w(cnt_w), .ser_w(ser_w),
    .rx_data(rx_data), .rx_count(rx_count));

  // 200 MHz clock
  always #2.5 pclk = ~pclk;

  task automatic print_verdict();
    if (err_total == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One APB transfer; the request is held until pready is sampled high
  task automatic apb(input logic w, input logic [5:0] a, input logic [7:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    rd_q = prdata;
    e_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // A slave that never answers ends the run
    if (n >= 40) begin
      err_total++;
      print_verdict();
    end else begin
      @(posedge pclk);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input string nm, input logic [5:0] a, input logic [7:0] exp);
    apb(1'b0, a, 8'h00);
    chk(nm, rd_q, {24'h000000, exp});
  endtask

  // Mains pulses, slow enough for the two-stage synchroniser
  task automatic tick(input int n);
    repeat (n) begin
      mains <= 1'b1;
      repeat (4) @(posedge pclk);
      mains <= 1'b0;
      repeat (4) @(posedge pclk);
    end
  endtask

  // Timer A underflow pulses, one every four cycles
  task automatic uf(input int n);
    repeat (n) begin
      ta_uf <= 1'b1;
      @(posedge pclk);
      ta_uf <= 1'b0;
      repeat (3) @(posedge pclk);
    end
  endtask

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, ta_uf, ta_run, tb_uf, mains} = 7'h00;
    edge_pin = 1'b1;
    paddr = 6'h00;
    pwdata = 32'h00000000;
    err_total = 0;
    checks = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd("irq_reset", A_IRQ, 8'h00);
    chk("irq_line_reset", irq_n, 1'b1);
    chk("clock_pin_reset", cnt_w, 1'b1);
    chk("pin_drive_low", {cnt_o, ser_o}, 2'b00);
    // Index below the block is refused
    apb(1'b0, 6'h00, 8'h00);
    chk("unmapped_err", e_q, 1'b1);
    // Alarm at 12:00:00.1, 50 Hz input
    wr(A_CA, 8'h80);
    wr(A_CB, 8'h80);
    wr(A_HR, 8'h12);
    wr(A_MIN, 8'h00);
    wr(A_SEC, 8'h00);
    wr(A_TEN, 8'h01);
    wr(A_CB, 8'h00);
    wr(A_IRQ, 8'h84);
    // Time 11:59:59.9 PM; pulses before the tenths write must not count
    wr(A_HR, 8'h91);
    wr(A_MIN, 8'h59);
    wr(A_SEC, 8'h59);
    tick(5);
    wr(A_TEN, 8'h09);
    rd("sec_stopped", A_SEC, 8'h59);
    tick(5);
    rd("hours_wrap", A_HR, 8'h12);
    tick(5);
    rd("min_latched", A_MIN, 8'h00);
    rd("ten_latched", A_TEN, 8'h00);
    rd("ten_live", A_TEN, 8'h01);
    chk("irq_line_alarm", irq_n, 1'b0);
    rd("irq_alarm", A_IRQ, 8'h84);
    chk("irq_line_released", irq_n, 1'b1);
    rd("irq_cleared", A_IRQ, 8'h00);
    // 60 Hz input needs six pulses per tenth
    wr(A_CA, 8'h00);
    tick(5);
    rd("ten_60hz_wait", A_TEN, 8'h01);
    tick(1);
    rd("ten_60hz_step", A_TEN, 8'h02);
    // Hours write on a running clock stops it
    wr(A_HR, 8'h12);
    tick(6);
    rd("ten_hours_stop", A_TEN, 8'h02);
    // Mask set then clear leaves only serial enabled
    wr(A_IRQ, 8'h89);
    wr(A_IRQ, 8'h05);
    ta_uf <= 1'b1;
    tb_uf <= 1'b1;
    @(posedge pclk);
    ta_uf <= 1'b0;
    tb_uf <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("irq_line_unmasked", irq_n, 1'b1);
    rd("irq_timers", A_IRQ, 8'h03);
    edge_pin <= 1'b0;
    repeat (6) @(posedge pclk);
    edge_pin <= 1'b1;
    rd("irq_edge", A_IRQ, 8'h10);
    // Transmit two bytes back to back
    wr(A_CA, 8'hC0);
    ta_run <= 1'b1;
    c0 = rx_count;
    wr(A_SER, 8'hA5);
    wr(A_SER, 8'h3C);
    uf(16);
    chk("tx_first", rx_data, 8'hA5);
    uf(16);
    chk("tx_second", rx_data, 8'h3C);
    uf(4);
    chk("tx_bits", rx_count - c0, 8'h10);
    chk("tx_clock_idle", cnt_w, 1'b1);
    chk("tx_data_hold", ser_w, 1'b0);
    rd("irq_tx", A_IRQ, 8'h89);
    // Receive one byte from the peer
    ta_run <= 1'b0;
    wr(A_CA, 8'h80);
    u_tcs_peer.send(8'h5A, 4);
    repeat (6) @(posedge pclk);
    rd("rx_byte", A_SER, 8'h5A);
    rd("irq_rx", A_IRQ, 8'h88);
    print_verdict();
  end
endmodule
